// ---- design/ss_startup_seq.sv ----
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`default_nettype none
// Notes on behaviour
// - Startup cell conducts from cold start until the controller is enabled.
// - Above turn-on threshold: startup cell off, controller enabled.
// - After enable, a boot interval of about 1.2 ms runs before switching.
// - After enable, bulk and supply brown-in are both evaluated continuously.
// - First soft-start main gate pulse needs both brown-ins and elapsed boot.
// - Until brown-in the general-purpose pin works as a single-wire UART.
// - In normal operation UART is off and the pin is weakly pulled down.
// - Auxiliary gate pulse starts each forced resonant cycle, apart from main gate.
// - Measurement unit stays on if supply drops before brown-in, until off threshold.
module ss_startup_seq
	import ss_pkg::*;
#(
	parameter int BOOT_CNT = BOOT_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Analog comparator results
	input  wire logic        supply_above_turn_on,
	input  wire logic        supply_brown_in_ok,
	input  wire logic        bulk_brown_in_ok,
	input  wire logic        supply_below_off,
	// Supply path control
	output logic             startup_cell_on,
	output logic             ctrl_enable,
	output logic             meas_active,
	// Gate drivers
	output logic             main_gate_out,
	output logic             resonant_gate_out,
	// General-purpose pin and UART core side
	input  wire logic        gpio_in,
	output logic             gpio_out,
	output logic             gpio_oe,
	output logic             gpio_weak_pd,
	input  wire logic        uart_tx,
	input  wire logic        uart_tx_oe,
	output logic             uart_rx
);

	////////////////////////////////////////////////////////////////////////////
	ss_reg_if rif ();

	ss_ahb_regs u_regs (
		.clk       (clk),
		.nrst      (nrst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rif       (rif)
	);

	// True when cnt lies in [lo, lo+len)
	function automatic logic in_window(input logic [15:0] cnt, input logic [15:0] lo,
		input logic [15:0] len);
		logic [16:0] hi;
		hi = {1'b0, lo} + {1'b0, len};
		return ({1'b0, cnt} >= {1'b0, lo}) && ({1'b0, cnt} < hi);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	ss_state_t   state;
	ss_state_t   next_state;
	logic [31:0] boot_cnt;
	logic [31:0] next_boot_cnt;
	logic        boot_done;
	logic        next_boot_done;
	logic        supply_dropped;
	logic        next_supply_dropped;
	logic        both_bi;

	assign both_bi = supply_brown_in_ok && bulk_brown_in_ok;

	// Sequencer: cold start, boot interval, brown-in wait, soft-started run
	always_comb
	begin
		next_state          = state;
		next_boot_cnt       = boot_cnt;
		next_boot_done      = boot_done;
		next_supply_dropped = supply_dropped;
		case (state)
			SS_COLD:
			begin
				next_boot_cnt       = 32'h0;
				next_boot_done      = 1'b0;
				next_supply_dropped = 1'b0;
				if (supply_above_turn_on)
					next_state = SS_BOOT;
			end
			SS_BOOT:
			begin
				next_boot_cnt = boot_cnt + 32'h1;
				if (boot_cnt >= 32'(BOOT_CNT - 1))
				begin
					next_boot_done = 1'b1;
					next_state     = both_bi ? SS_RUN : SS_WAIT;
				end
			end
			SS_WAIT:
				if (both_bi)
					next_state = SS_RUN;
			SS_RUN:     ;
			default:    next_state = SS_COLD;
		endcase
		// Supply sagging under brown-in before brown-in was seen: set the dropped flag
		if ((state == SS_BOOT || state == SS_WAIT) && !supply_brown_in_ok)
			next_supply_dropped = 1'b1;
		if (supply_below_off)
			next_state = SS_COLD;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state          <= SS_COLD;
			boot_cnt       <= 32'h0;
			boot_done      <= 1'b0;
			supply_dropped <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			boot_cnt       <= next_boot_cnt;
			boot_done      <= next_boot_done;
			supply_dropped <= next_supply_dropped;
		end
	end

	assign rif.status = {state, 1'b0, supply_dropped, boot_done, both_bi};

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] pwm_cnt;
	logic [15:0] next_pwm_cnt;
	logic [15:0] on_time;
	logic [15:0] next_on_time;
	logic [16:0] stepped;
	logic [15:0] main_lo;
	logic        run_next;

	// Soft-start PWM: on-time grows by a fixed step each period up to the limit
	always_comb
	begin
		run_next     = (next_state == SS_RUN);
		next_pwm_cnt = 16'h0;
		next_on_time = SS_START;
		stepped      = {1'b0, on_time} + {1'b0, SS_STEP};
		if (state == SS_RUN && run_next)
		begin
			next_on_time = on_time;
			next_pwm_cnt = pwm_cnt + 16'h1;
			if (pwm_cnt >= rif.period - 16'h1)
			begin
				next_pwm_cnt = 16'h0;
				if (stepped > {1'b0, rif.on_max})
					next_on_time = rif.on_max;
				else
					next_on_time = stepped[15:0];
			end
		end
		// Main pulse follows the resonant pulse when forced resonance is enabled
		main_lo = rif.fqr_en ? RES_WIDTH : 16'h0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwm_cnt <= 16'h0;
			on_time <= SS_START;
		end
		else
		begin
			pwm_cnt <= next_pwm_cnt;
			on_time <= next_on_time;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered pin outputs; gates only in run, so lockout silences both at once
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			startup_cell_on   <= 1'b1;
			ctrl_enable       <= 1'b0;
			meas_active       <= 1'b0;
			main_gate_out     <= 1'b0;
			resonant_gate_out <= 1'b0;
			gpio_out          <= 1'b0;
			gpio_oe           <= 1'b0;
			gpio_weak_pd      <= 1'b0;
			uart_rx           <= 1'b1;
		end
		else
		begin
			startup_cell_on   <= (next_state == SS_COLD);
			ctrl_enable       <= (next_state != SS_COLD);
			meas_active       <= (next_state != SS_COLD);
			main_gate_out     <= (state == SS_RUN) && run_next
				&& in_window(pwm_cnt, main_lo, on_time);
			resonant_gate_out <= (state == SS_RUN) && run_next && rif.fqr_en
				&& in_window(pwm_cnt, 16'h0, RES_WIDTH);
			// UART owns the pin until brown-in, then a weak pull-down only
			gpio_out          <= run_next ? 1'b0 : uart_tx;
			gpio_oe           <= run_next ? 1'b0 : uart_tx_oe;
			gpio_weak_pd      <= run_next;
			uart_rx           <= run_next ? 1'b1 : gpio_in; // Idle-high when off
		end
	end
endmodule // ss_startup_seq
`default_nettype wire

// ---- common/ss_pkg.sv ----
`default_nettype none
package ss_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int BOOT_TIME_NS  = 1200000;
	localparam int BOOT_CYCLES   = BOOT_TIME_NS / CLK_PERIOD_NS;

	// Register map (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_PERIOD = 8'h04;
	localparam logic [7:0] REG_ONMAX  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;

	// Field positions
	localparam int CTRL_FQR_BIT = 0;
	localparam int STATUS_W     = 8;

	// Reset values and soft-start figures, in clock cycles
	localparam logic        CTRL_FQR_RST = 1'b0;
	localparam logic [15:0] PERIOD_RST   = 16'h03E8;
	localparam logic [15:0] ONMAX_RST    = 16'h0190;
	localparam logic [15:0] SS_START     = 16'h0010;
	localparam logic [15:0] SS_STEP      = 16'h0004;
	localparam logic [15:0] RES_WIDTH    = 16'h0020;

	// Sequencer states
	typedef enum logic [3:0] {
		SS_COLD = 4'h1,
		SS_BOOT = 4'h2,
		SS_WAIT = 4'h4,
		SS_RUN  = 4'h8
	} ss_state_t;
endpackage
`default_nettype wire

// ---- common/ss_reg_if.sv ----
`default_nettype none
interface ss_reg_if;
	logic        fqr_en;
	logic [15:0] period;
	logic [15:0] on_max;
	logic [7:0]  status;

	modport regs (output fqr_en, output period, output on_max, input status);
	modport core (input fqr_en, input period, input on_max, output status);
endinterface
`default_nettype wire

// ---- design/ss_ahb_regs.sv ----
`default_nettype none
module ss_ahb_regs
	import ss_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Register carrier
	ss_reg_if.regs           rif
);

	////////////////////////////////////////////////////////////////////////////
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        fqr_en;
	logic [15:0] period;
	logic [15:0] on_max;
	logic        next_wr_pend;
	logic [7:0]  next_wr_addr;
	logic        next_fqr_en;
	logic [15:0] next_period;
	logic [15:0] next_on_max;
	logic [31:0] next_hrdata;
	logic        addr_ok;

	assign rif.fqr_en = fqr_en;
	assign rif.period = period;
	assign rif.on_max = on_max;

	// Address phase capture; reads are served from a register so no wait state is needed
	always_comb
	begin
		addr_ok      = hsel && htrans[1] && hready && (hsize == 3'h2);
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
		next_hrdata  = hrdata;
		if (addr_ok && !hwrite)
		begin
			case (haddr[7:0])
				REG_CTRL:   next_hrdata = {31'h0, fqr_en};
				REG_PERIOD: next_hrdata = {16'h0, period};
				REG_ONMAX:  next_hrdata = {16'h0, on_max};
				REG_STATUS: next_hrdata = {24'h0, rif.status};
				default:    next_hrdata = 32'h0; // Unmapped reads as zero
			endcase
		end
		next_fqr_en = fqr_en;
		next_period = period;
		next_on_max = on_max;
		if (wr_pend)
		begin
			case (wr_addr)
				REG_CTRL:   next_fqr_en = hwdata[CTRL_FQR_BIT];
				REG_PERIOD: next_period = hwdata[15:0];
				REG_ONMAX:  next_on_max = hwdata[15:0];
				default:    ; // Unmapped and status writes are dropped
			endcase
		end
	end

	// Register stage
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			fqr_en    <= CTRL_FQR_RST;
			period    <= PERIOD_RST;
			on_max    <= ONMAX_RST;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			wr_pend   <= next_wr_pend;
			wr_addr   <= next_wr_addr;
			fqr_en    <= next_fqr_en;
			period    <= next_period;
			on_max    <= next_on_max;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule // ss_ahb_regs
`default_nettype wire

// ---- sim/ss_startup_seq_properties.sv ----
`default_nettype none
module ss_seq_props
#(
	parameter int BOOT_CNT = 50
)
(
	// Clock, reset, comparators
	input wire logic clk,
	input wire logic nrst,
	input wire logic supply_above_turn_on,
	input wire logic supply_brown_in_ok,
	input wire logic bulk_brown_in_ok,
	input wire logic supply_below_off,
	// Supply path and gates
	input wire logic startup_cell_on,
	input wire logic ctrl_enable,
	input wire logic meas_active,
	input wire logic main_gate_out,
	input wire logic resonant_gate_out,
	// Pin and UART
	input wire logic gpio_in,
	input wire logic gpio_oe,
	input wire logic gpio_weak_pd,
	input wire logic uart_tx_oe,
	input wire logic uart_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles spent enabled; saturates so a long run never wraps
	logic [19:0] en_cnt;
	logic [19:0] next_en_cnt;
	always_comb
	begin
		next_en_cnt = !ctrl_enable ? 20'h0 : (&en_cnt) ? en_cnt : en_cnt + 20'h1;
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			en_cnt <= 20'h0;
		else
			en_cnt <= next_en_cnt;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
////////////////////////////////////////////////////////////////
	cell_cold_a:
		assert property (!ctrl_enable |-> startup_cell_on) else $error("cell off while cold");
	turn_on_a:
		assert property (!ctrl_enable && supply_above_turn_on && !supply_below_off
			|=> ctrl_enable && !startup_cell_on) else $error("turn-on ignored");
	boot_hold_a:
		assert property (main_gate_out || resonant_gate_out || gpio_weak_pd
			|-> en_cnt >= BOOT_CNT) else $error("switching inside boot");
	run_brown_a:
		assert property ($rose(gpio_weak_pd) |-> $past(supply_brown_in_ok && bulk_brown_in_ok))
			else $error("run without brown-in");
	uart_mux_a:
		assert property (!gpio_weak_pd && !$past(gpio_weak_pd) |-> gpio_oe == $past(uart_tx_oe)
			&& uart_rx == $past(gpio_in)) else $error("pin not in uart use");
	pd_run_a:
		assert property (gpio_weak_pd |-> !gpio_oe && uart_rx) else $error("pin driven in run");
	res_width_a:
		assert property ($rose(resonant_gate_out) |-> !main_gate_out ##31 resonant_gate_out
			##1 !resonant_gate_out && main_gate_out) else $error("resonant pulse wrong");
	meas_hold_a:
		assert property (meas_active && !supply_below_off |=> meas_active && ctrl_enable)
			else $error("measurement dropped");
	uvlo_stop_a:
		assert property (supply_below_off |=> !main_gate_out && !resonant_gate_out
			&& startup_cell_on && !ctrl_enable) else $error("undervoltage not obeyed");
endmodule // ss_seq_props

bind ss_startup_seq ss_seq_props #(.BOOT_CNT(BOOT_CNT)) u_props (.clk, .nrst,
	.supply_above_turn_on, .supply_brown_in_ok, .bulk_brown_in_ok, .supply_below_off,
	.startup_cell_on, .ctrl_enable, .meas_active, .main_gate_out, .resonant_gate_out,
	.gpio_in, .gpio_oe, .gpio_weak_pd, .uart_tx_oe, .uart_rx);
`default_nettype wire

// ---- sim/ss_supply_model.sv ----
`default_nettype none
module ss_supply_model
#(
	parameter int CHARGE = 40
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Startup cell and comparator
	input  wire logic startup_cell_on,
	output logic      supply_above_turn_on
);
	timeunit 1ns;
	timeprecision 1ps;
	// Supply charge; the cell fills it, the load drains it once the cell is off
	int lvl;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			lvl <= 0;
		else if (startup_cell_on && lvl < CHARGE)
			lvl <= lvl + 1;
		else if (!startup_cell_on && lvl > 0)
			lvl <= lvl - 1;
	end
	// Threshold crossing seen by the turn-on comparator
	assign supply_above_turn_on = (lvl >= CHARGE);
endmodule // ss_supply_model
`default_nettype wire

// ---- sim/tb.sv ----
`default_nettype none
module tb import ss_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BOOT = 50;
	logic        clk, nrst, hsel, hwrite, hresp, hreadyout;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        supply_above_turn_on, supply_brown_in_ok, bulk_brown_in_ok, supply_below_off;
	logic        startup_cell_on, ctrl_enable, meas_active, main_gate_out, resonant_gate_out;
	logic        gpio_in, gpio_out, gpio_oe, gpio_weak_pd, uart_tx, uart_tx_oe, uart_rx;
	int          failures, n_checks, cyc, k, n;
	// Block with a short boot, and the supply it charges
	ss_startup_seq #(.BOOT_CNT(BOOT)) uut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .supply_above_turn_on,
		.supply_brown_in_ok, .bulk_brown_in_ok, .supply_below_off, .startup_cell_on,
		.ctrl_enable, .meas_active, .main_gate_out, .resonant_gate_out, .gpio_in, .gpio_out,
		.gpio_oe, .gpio_weak_pd, .uart_tx, .uart_tx_oe, .uart_rx);
	ss_supply_model #(.CHARGE(40)) sup (.clk, .nrst, .startup_cell_on, .supply_above_turn_on);
////////////////////////////////////////////////////////////////
	// Time-zero values and clock
	initial
	begin
		{nrst, hsel, hwrite, hwdata, haddr, htrans, supply_brown_in_ok, bulk_brown_in_ok} = '0;
		{supply_below_off, uart_tx, uart_tx_oe, failures, n_checks, cyc} = '0;
		hsize = 3'h2;
		gpio_in = 1'b1;
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			$display("[FAIL] %0t run limit reached", $time);
			close_out();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// Single word transfer; address held until hready, then the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(hresp, 0, "bus error");
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
////////////////////////////////////////////////////////////////
	// Sampling happens 1 ns after an edge so registered outputs have settled
	task automatic t_cold;
		#1;
		chk({startup_cell_on, ctrl_enable}, 2'b10, "cold start state");
		@(posedge clk);
		uart_tx_oe <= 1'b1;
		uart_tx <= 1'b1;
		gpio_in <= 1'b0;
		#1;
		repeat (2) #10;
		chk({gpio_oe, gpio_out, uart_rx}, 3'b110, "uart pin mux");
		for (k = 0; k < 200 && ctrl_enable !== 1'b1; k++) #10;
		chk({startup_cell_on, meas_active}, 2'b01, "turn-on not obeyed");
		repeat (BOOT + 10) #10;
		chk({main_gate_out, gpio_weak_pd, meas_active}, 3'b001, "ran without brown-in");
		// Waiting with the supply under brown-in must leave the dropped flag in status
		ahb(1'b0, REG_STATUS, 32'h0, rd);
		chk(rd, {24'h0, SS_WAIT, 4'b0110}, "drop before brown-in not flagged");
		@(posedge clk);
		supply_brown_in_ok <= 1'b1;
		#1;
		repeat (5) #10;
		chk(main_gate_out, 0, "gate on one brown-in");
		@(posedge clk);
		bulk_brown_in_ok <= 1'b1;
		#1;
		for (k = 0; k < 20 && main_gate_out !== 1'b1; k++) #10;
		chk(main_gate_out, 1, "no first gate pulse");
		chk({gpio_oe, gpio_out, gpio_weak_pd, uart_rx}, 4'b0011, "pin not released");
		$display("cold start test done");
	endtask
	task automatic t_uvlo;
		@(posedge clk);
		supply_below_off <= 1'b1;
		@(posedge clk);
		supply_below_off <= 1'b0;
		#1;
		chk({main_gate_out, resonant_gate_out, startup_cell_on, ctrl_enable}, 4'b0010,
			"undervoltage");
		$display("undervoltage test done");
	endtask
	task automatic t_regs;
		ahb(1'b0, REG_PERIOD, 32'h0, rd);
		chk(rd, 32'(PERIOD_RST), "period reset");
		ahb(1'b0, REG_ONMAX, 32'h0, rd);
		chk(rd, 32'(ONMAX_RST), "on limit reset");
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		ahb(1'b1, REG_CTRL, 32'h1, rd);
		ahb(1'b0, REG_CTRL, 32'h0, rd);
		chk(rd, 32'h1, "resonant enable");
		$display("register test done");
	endtask
	// Restart with both brown-ins already present and resonant pulses on
	task automatic t_fqr;
		#1;
		for (k = 0; k < 200 && ctrl_enable !== 1'b1; k++) #10;
		for (k = 0; k < 200 && gpio_weak_pd !== 1'b1; k++) #10;
		chk(k, BOOT, "boot length");
		for (n = 0; n < 10 && resonant_gate_out !== 1'b1; n++) #10;
		for (n = 0; n < 100 && resonant_gate_out === 1'b1; n++) #10;
		chk(n, 32'(RES_WIDTH), "resonant width");
		chk(main_gate_out, 1, "main after resonant");
		// First main pulse is the soft-start width; also lets the width property finish
		for (n = 0; n < 100 && main_gate_out === 1'b1; n++) #10;
		chk(n, 32'(SS_START), "first soft-start pulse");
		$display("resonant test done");
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_cold();
		t_uvlo();
		t_regs();
		t_fqr();
		close_out();
	end
endmodule // tb
`default_nettype wire
